// ==== hdl/ltcr_top.v ====
/*
 Link training configuration register bank and its steering outputs.
 Assumes a plain register port with read data one cycle after the
 read strobe, and a training machine that consumes the outputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ltcr_regs.vh"
module ltcr_top #(
	parameter LANES = 16,
	parameter [1:0] SUPPORTED_RATE = 2'h3
) (
	input wire CLK_I,
	input wire ARST_N_I,
	input wire [7:0] ADDR_I,
	input wire [31:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [31:0] RDATA_O,
	input wire [LANES-1:0] LANE_DETECTED_I,
	input wire DETECT_I,
	input wire L0_ENTRY_I,
	input wire [1:0] PARTNER_RATE_I,
	input wire IDLE_STATE_ENTRY_I,
	input wire RX_ELEC_IDLE_I,
	input wire [3:0] INFER_STATE_I,
	input wire RX_TS_REQ_I,
	input wire L2_WAKE_REQ_I,
	input wire MODPAT_ACTIVE_I,
	input wire ENTER_COMPLIANCE_I,
	output wire [LANES-1:0] LANE_DETECT_EN_O,
	output wire [LANES-1:0] LANE_INCLUDE_O,
	output wire [4:0] LINK_NUMBER_O,
	output wire [7:0] NFTS_O,
	output wire [8:0] FTS_TIMEOUT_SETS_O,
	output wire SPEED_REQ_O,
	output wire [1:0] SPEED_TARGET_O,
	output wire DEEMPH_SELECT_O,
	output wire BEACON_O,
	output wire WAKE_PIN_O,
	output wire [3:0] EIEOS_COUNT_O,
	output wire MODPAT_EXIT_O,
	output wire INFER_COUNT_EN_O,
	output wire IDLE_QUAL_O,
	output wire [1:0] PAT_MAX_SPEED_O,
	output wire [1:0] PAT_MIN_SPEED_O,
	output wire [3:0] TS_ENTRY_ALLOW_O
);
	reg port_direction_select_r;
	reg [4:0] link_num_r;
	reg override_r;
	reg [15:0] mask_r;
	reg [7:0] nfts_r;
	reg [7:0] fts_timeout_extension_r;
	reg rate_enable_r;
	reg [1:0] rate_r;
	reg deemph_select_r;
	reg beacon_wake_enable_r;
	reg one_eieos_r;
	reg pattern_exit_select_r;
	reg infer_include_lock_r;
	reg infer_include_rcvcfg_r;
	reg infer_include_equalize_r;
	reg [3:0] filter_r;
	reg [1:0] max_speed_r;
	reg [1:0] min_speed_r;
	reg [3:0] ts_block_r;
	reg [31:0] rdata_nxt;
	wire [1:0] rate_legal;
	wire [LANES-1:0] mask_l;
	wire downstream;
	wire speed_req;
	wire [1:0] speed_target;
	wire idle_qual;

	function [1:0] clip_rate;
		input [1:0] r;
		clip_rate = (r > SUPPORTED_RATE) ? SUPPORTED_RATE : r;
	endfunction

	assign downstream = port_direction_select_r;
	assign rate_legal = clip_rate(rate_r);
	assign mask_l = mask_r[LANES-1:0];

	always @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			port_direction_select_r <= 1'b0;
			link_num_r <= `LTCR_RST_LINKNUM;
			override_r <= 1'b0;
			mask_r <= `LTCR_RST_MASK;
			nfts_r <= `LTCR_RST_NFTS;
			fts_timeout_extension_r <= `LTCR_RST_EXTEND;
			rate_enable_r <= 1'b0;
			rate_r <= `LTCR_RST_RATE;
			deemph_select_r <= `LTCR_RST_DEEMPH;
			beacon_wake_enable_r <= 1'b0;
			one_eieos_r <= `LTCR_RST_ONE_EIEOS;
			pattern_exit_select_r <= 1'b0;
			infer_include_lock_r <= 1'b0;
			infer_include_rcvcfg_r <= 1'b0;
			infer_include_equalize_r <= 1'b0;
			filter_r <= `LTCR_RST_FILTER;
			max_speed_r <= `LTCR_RST_MAXSPD;
			min_speed_r <= `LTCR_RST_MINSPD;
			ts_block_r <= 4'h0;
		end else if (WR_I) begin
			case (ADDR_I)
			`LTCR_OFS_PORT: begin
				port_direction_select_r <= WDATA_I[0];
			end
			`LTCR_OFS_LINKNUM: begin
				link_num_r <= WDATA_I[4:0];
			end
			`LTCR_OFS_LANEDET: begin
				override_r <= WDATA_I[`LTCR_BIT_TOP];
				mask_r <= WDATA_I[15:0];
			end
			`LTCR_OFS_FTS: begin
				nfts_r <= WDATA_I[7:0];
				fts_timeout_extension_r <= WDATA_I[15:8];
			end
			`LTCR_OFS_SPEED: begin
				rate_enable_r <= WDATA_I[`LTCR_BIT_TOP];
				rate_r <= WDATA_I[1:0];
			end
			`LTCR_OFS_DEEMPH: begin
				deemph_select_r <= WDATA_I[0];
			end
			`LTCR_OFS_BEACON: begin
				beacon_wake_enable_r <= WDATA_I[0];
			end
			`LTCR_OFS_MODPAT: begin
				one_eieos_r <= WDATA_I[1];
				pattern_exit_select_r <= WDATA_I[0];
			end
			`LTCR_OFS_IDLE: begin
				infer_include_lock_r <= WDATA_I[`LTCR_BIT_TOP];
				infer_include_rcvcfg_r <= WDATA_I[`LTCR_BIT_CFG];
				infer_include_equalize_r <= WDATA_I[`LTCR_BIT_EQ];
				filter_r <= WDATA_I[3:0];
			end
			`LTCR_OFS_PATSPD: begin
				max_speed_r <= WDATA_I[3:2];
				min_speed_r <= WDATA_I[1:0];
			end
			`LTCR_OFS_TSBLK: begin
				ts_block_r <= WDATA_I[3:0];
			end
			default: begin
				link_num_r <= link_num_r;
			end
			endcase
		end
	end

	// Read mux, reserved bits zero
	always @* begin
		rdata_nxt = 32'h00000000;
		case (ADDR_I)
		`LTCR_OFS_PORT: rdata_nxt[0] = port_direction_select_r;
		`LTCR_OFS_LINKNUM: rdata_nxt[4:0] = link_num_r;
		`LTCR_OFS_LANEDET: begin
			rdata_nxt[`LTCR_BIT_TOP] = override_r;
			rdata_nxt[15:0] = mask_r;
		end
		`LTCR_OFS_FTS: rdata_nxt[15:0] = {fts_timeout_extension_r, nfts_r};
		`LTCR_OFS_SPEED: begin
			rdata_nxt[`LTCR_BIT_TOP] = rate_enable_r;
			rdata_nxt[1:0] = rate_r;
		end
		`LTCR_OFS_DEEMPH: rdata_nxt[0] = deemph_select_r;
		`LTCR_OFS_BEACON: rdata_nxt[0] = beacon_wake_enable_r;
		`LTCR_OFS_MODPAT: rdata_nxt[1:0] = {one_eieos_r, pattern_exit_select_r};
		`LTCR_OFS_IDLE: begin
			rdata_nxt[`LTCR_BIT_TOP] = infer_include_lock_r;
			rdata_nxt[`LTCR_BIT_CFG] = infer_include_rcvcfg_r;
			rdata_nxt[`LTCR_BIT_EQ] = infer_include_equalize_r;
			rdata_nxt[3:0] = filter_r;
		end
		`LTCR_OFS_PATSPD: rdata_nxt[3:0] = {max_speed_r, min_speed_r};
		`LTCR_OFS_TSBLK: rdata_nxt[3:0] = ts_block_r;
		`LTCR_OFS_STAT: begin
			rdata_nxt[3:2] = speed_target;
			rdata_nxt[1] = speed_req;
			rdata_nxt[0] = idle_qual;
		end
		default: rdata_nxt = 32'h00000000;
		endcase
	end

	always @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			RDATA_O <= 32'h00000000;
		end else if (RD_I) begin
			RDATA_O <= rdata_nxt;
		end else begin
			RDATA_O <= 32'h00000000;
		end
	end

	// Lane detection masking
	assign LANE_DETECT_EN_O = override_r ? mask_l :
		{LANES{1'b1}};
	assign LANE_INCLUDE_O = LANE_DETECT_EN_O & LANE_DETECTED_I;

	assign LINK_NUMBER_O = downstream ? link_num_r : 5'h00;
	assign NFTS_O = nfts_r;
	assign FTS_TIMEOUT_SETS_O = {1'b0, nfts_r} +
		{1'b0, fts_timeout_extension_r};

	ltcr_speed_up u_speed_up (
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.enable_i(rate_enable_r),
		.rate_i(rate_legal),
		.supported_i(SUPPORTED_RATE),
		.partner_i(PARTNER_RATE_I),
		.detect_i(DETECT_I),
		.l0_entry_i(L0_ENTRY_I),
		.req_o(speed_req),
		.target_o(speed_target)
	);
	assign SPEED_REQ_O = speed_req;
	assign SPEED_TARGET_O = speed_target;

	assign DEEMPH_SELECT_O = !downstream && deemph_select_r;
	assign BEACON_O = L2_WAKE_REQ_I && beacon_wake_enable_r;
	assign WAKE_PIN_O = L2_WAKE_REQ_I && !beacon_wake_enable_r;
	assign EIEOS_COUNT_O = one_eieos_r ? 4'h1 : `LTCR_EIEOS_MANY;
	assign MODPAT_EXIT_O = MODPAT_ACTIVE_I && !ENTER_COMPLIANCE_I &&
		pattern_exit_select_r;

	// INFER_STATE_I: 0 speed, 1 rcvrlock, 2 rcvrcfg, 3 equalize
	assign INFER_COUNT_EN_O = INFER_STATE_I[0] |
		(INFER_STATE_I[1] & infer_include_lock_r) |
		(INFER_STATE_I[2] & infer_include_rcvcfg_r) |
		(INFER_STATE_I[3] & infer_include_equalize_r);

	ltcr_idle_filter u_idle_filter (
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.state_entry_i(IDLE_STATE_ENTRY_I),
		.filter_i(filter_r),
		.rx_elec_idle_i(RX_ELEC_IDLE_I),
		.idle_qual_o(idle_qual)
	);
	assign IDLE_QUAL_O = idle_qual;

	assign PAT_MAX_SPEED_O = max_speed_r;
	assign PAT_MIN_SPEED_O = min_speed_r;
	// Bit3 compliance, 2 loopback, 1 hot reset, 0 disabled
	assign TS_ENTRY_ALLOW_O = {4{RX_TS_REQ_I}} & ~ts_block_r;
endmodule // ltcr_top
`default_nettype wire

// ==== inc/ltcr_regs.vh ====
/*
 Offsets, field positions, reset values and timing for the link
 training configuration bank. Assumes a 50 MHz core clock.
*/
// What this block does
// - Downstream link number, 5 bits, reset zero
// - Override set: mask picks detecting lanes
// - Mask zero lane skips detect, excluded
// - FTS request count, reset all ones
// - L0s exit timeout adds extension set times
// - Speed-up enable: one attempt after L0
// - Achieved speed: highest common at or below
// - Target rate encoding, supported only, reset zero
// - Deemphasis select, upstream 5G, reset one
// - Beacon enable allows L2 wake beacon
// - Single EIEOS bit, else eight blocks
// - Exit-select decides modified pattern exit
// - Include RcvrLock time in inference
// - Include RcvrCfg and EQ time, reset zero
// - Ignore rx idle 128 ns times filter
// - Compliance speed bounds, max three, min zero
// - Block compliance and loopback TS entry
// - Block hot reset and disabled TS entry
// - Port direction selects upstream or downstream
`ifndef LTCR_REGS_VH
`define LTCR_REGS_VH
`define LTCR_OFS_PORT 8'h40
`define LTCR_OFS_LINKNUM 8'h48
`define LTCR_OFS_LANEDET 8'h4C
`define LTCR_OFS_FTS 8'h50
`define LTCR_OFS_SPEED 8'h54
`define LTCR_OFS_DEEMPH 8'h58
`define LTCR_OFS_BEACON 8'h5C
`define LTCR_OFS_MODPAT 8'h60
`define LTCR_OFS_IDLE 8'h64
`define LTCR_OFS_PATSPD 8'h68
`define LTCR_OFS_TSBLK 8'h6C
`define LTCR_OFS_STAT 8'h70
`define LTCR_RST_LINKNUM 5'h00
`define LTCR_RST_MASK 16'h0000
`define LTCR_RST_NFTS 8'hFF
`define LTCR_RST_EXTEND 8'h7F
`define LTCR_RST_RATE 2'h0
`define LTCR_RST_DEEMPH 1'h1
`define LTCR_RST_ONE_EIEOS 1'h1
`define LTCR_RST_FILTER 4'h1
`define LTCR_RST_MAXSPD 2'h3
`define LTCR_RST_MINSPD 2'h0
`define LTCR_BIT_TOP 31
`define LTCR_BIT_CFG 30
`define LTCR_BIT_EQ 29
`define LTCR_FILTER_NS 128
`define LTCR_CLK_NS 20
`define LTCR_FILTER_CYC ((`LTCR_FILTER_NS + `LTCR_CLK_NS - 1) / `LTCR_CLK_NS)
`define LTCR_EIEOS_MANY 4'h8
`endif

// ==== hdl/ltcr_idle_filter.v ====
/*
 Receive electrical idle blanking timer.
 Assumes state_entry pulses when a state watching idle is entered.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ltcr_regs.vh"
module ltcr_idle_filter (
	input wire clk_i,
	input wire arst_n_i,
	input wire state_entry_i,
	input wire [3:0] filter_i,
	input wire rx_elec_idle_i,
	output reg idle_qual_o
);
	localparam integer UNIT_CYC = `LTCR_FILTER_CYC;
	localparam [3:0] UNIT = UNIT_CYC[3:0];
	reg [7:0] cnt_r;
	reg [3:0] unit_r;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= 8'h00;
			unit_r <= 4'h0;
			idle_qual_o <= 1'b0;
		end else begin
			if (state_entry_i) begin
				cnt_r <= {4'h0, filter_i};
				unit_r <= UNIT - 4'h1;
			end else if (cnt_r != 8'h00) begin
				if (unit_r == 4'h0) begin
					cnt_r <= cnt_r - 8'h01;
					unit_r <= UNIT - 4'h1;
				end else begin
					unit_r <= unit_r - 4'h1;
				end
			end
			idle_qual_o <= (cnt_r == 8'h00) && !state_entry_i &&
				rx_elec_idle_i;
		end
	end
endmodule // ltcr_idle_filter
`default_nettype wire

// ==== hdl/ltcr_speed_up.v ====
/*
 One-shot initial speed-up request after first L0 from Detect.
 Assumes l0_entry and detect pulses from the training machine.
*/
`timescale 1ns/1ns
`default_nettype none
module ltcr_speed_up (
	input wire clk_i,
	input wire arst_n_i,
	input wire enable_i,
	input wire [1:0] rate_i,
	input wire [1:0] supported_i,
	input wire [1:0] partner_i,
	input wire detect_i,
	input wire l0_entry_i,
	output reg req_o,
	output reg [1:0] target_o
);
	reg done_r;
	function [1:0] min2;
		input [1:0] a;
		input [1:0] b;
		min2 = (a < b) ? a : b;
	endfunction
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_r <= 1'b0;
			req_o <= 1'b0;
			target_o <= 2'h0;
		end else begin
			req_o <= 1'b0;
			if (detect_i) begin
				done_r <= 1'b0;
			end else if (l0_entry_i && !done_r) begin
				done_r <= 1'b1;
				req_o <= enable_i;
				target_o <= min2(min2(rate_i, supported_i),
					partner_i);
			end
		end
	end
endmodule // ltcr_speed_up
`default_nettype wire

// ==== tb/ltcr_top_monitor.sv ====
/* Port checker for the link training configuration bank.
 Bound to ltcr_top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module ltcr_top_monitor #(
	parameter LANES = 16,
	parameter [1:0] SUPPORTED_RATE = 2'h3
) (
	input wire CLK_I,
	input wire ARST_N_I,
	input wire RD_I,
	input wire [31:0] RDATA_O,
	input wire [LANES-1:0] LANE_DETECTED_I,
	input wire [LANES-1:0] LANE_DETECT_EN_O,
	input wire [LANES-1:0] LANE_INCLUDE_O,
	input wire L0_ENTRY_I,
	input wire [1:0] PARTNER_RATE_I,
	input wire SPEED_REQ_O,
	input wire [1:0] SPEED_TARGET_O,
	input wire L2_WAKE_REQ_I,
	input wire BEACON_O,
	input wire WAKE_PIN_O,
	input wire RX_TS_REQ_I,
	input wire [3:0] TS_ENTRY_ALLOW_O,
	input wire RX_ELEC_IDLE_I,
	input wire IDLE_QUAL_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	// Speed-up attempt answered one cycle after L0 entry
	sequence s_attempt;
		L0_ENTRY_I ##1 SPEED_REQ_O;
	endsequence
	AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
		else $error("read data outside read slot");
	AST_INCLUDE: assert property (
		LANE_INCLUDE_O == (LANE_DETECT_EN_O & LANE_DETECTED_I))
		else $error("lane include mismatch");
	AST_WAKE_ONE: assert property (L2_WAKE_REQ_I |-> BEACON_O != WAKE_PIN_O)
		else $error("wake path not exclusive");
	AST_WAKE_IDLE: assert property (!L2_WAKE_REQ_I |-> !BEACON_O && !WAKE_PIN_O)
		else $error("wake without request");
	AST_TS_ALLOW: assert property (!RX_TS_REQ_I |-> TS_ENTRY_ALLOW_O == 4'h0)
		else $error("ts entry without request");
	AST_SPEED_CAUSE: assert property (SPEED_REQ_O |-> $past(L0_ENTRY_I))
		else $error("speed request without L0 entry");
	AST_SPEED_ONCE: assert property (s_attempt |=> !SPEED_REQ_O [*2])
		else $error("speed request repeated");
	AST_SPEED_RATE: assert property (s_attempt |->
		SPEED_TARGET_O <= SUPPORTED_RATE && SPEED_TARGET_O <= $past(PARTNER_RATE_I))
		else $error("speed target above common rate");
	AST_IDLE_QUAL: assert property (IDLE_QUAL_O |-> $past(RX_ELEC_IDLE_I))
		else $error("idle qualified without idle");
endmodule // ltcr_top_monitor
bind ltcr_top ltcr_top_monitor #(.LANES(LANES),
	.SUPPORTED_RATE(SUPPORTED_RATE)) u_mon (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
/* Self-checking bench for the link training configuration bank.
 Drives the register port and training inputs directly. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, dtc = 0, l0 = 0, ient = 0;
	logic ridle = 1, tsq = 1, wak = 0, mpa = 1, ecp = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [15:0] det = 16'hFFFF;
	logic [1:0] prate = 2'h3;
	logic [3:0] ist = 4'h0;
	wire [31:0] rdat;
	wire [15:0] den, inc;
	wire [4:0] lnum;
	wire [7:0] nfts;
	wire [8:0] fto;
	wire [1:0] stgt, pmax, pmin;
	wire [3:0] eie, tsa;
	wire sreq, dmp, bcn, wpin, mex, icen, iq;
	integer err_count = 0, num_checks = 0, cyc = 0;
	logic [31:0] rv[10] = '{32'h0, 32'h0, 32'h7FFF, 32'h0, 32'h1, 32'h0,
		32'h2, 32'h1, 32'hC, 32'h0};
	logic [31:0] mv[10] = '{32'h1F, 32'h8000FFFF, 32'hFFFF, 32'h80000003,
		32'h1, 32'h1, 32'h3, 32'hE000000F, 32'hF, 32'hF};
	ltcr_top dut (.CLK_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr),
		.WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat),
		.LANE_DETECTED_I(det), .DETECT_I(dtc), .L0_ENTRY_I(l0),
		.PARTNER_RATE_I(prate), .IDLE_STATE_ENTRY_I(ient),
		.RX_ELEC_IDLE_I(ridle), .INFER_STATE_I(ist), .RX_TS_REQ_I(tsq),
		.L2_WAKE_REQ_I(wak), .MODPAT_ACTIVE_I(mpa),
		.ENTER_COMPLIANCE_I(ecp), .LANE_DETECT_EN_O(den),
		.LANE_INCLUDE_O(inc), .LINK_NUMBER_O(lnum), .NFTS_O(nfts),
		.FTS_TIMEOUT_SETS_O(fto), .SPEED_REQ_O(sreq),
		.SPEED_TARGET_O(stgt), .DEEMPH_SELECT_O(dmp), .BEACON_O(bcn),
		.WAKE_PIN_O(wpin), .EIEOS_COUNT_O(eie), .MODPAT_EXIT_O(mex),
		.INFER_COUNT_EN_O(icen), .IDLE_QUAL_O(iq),
		.PAT_MAX_SPEED_O(pmax), .PAT_MIN_SPEED_O(pmin),
		.TS_ENTRY_ALLOW_O(tsa));
	initial forever #10 clk = ~clk;
	task end_of_test;
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdat, e);
	endtask
	task attempt(input logic rearm, input logic e_req, input logic [1:0] e_t);
		@(posedge clk);
		dtc <= rearm;
		@(posedge clk);
		dtc <= 1'b0;
		l0 <= 1'b1;
		@(posedge clk);
		l0 <= 1'b0;
		#1 chk(sreq, e_req);
		if (e_req) chk(stgt, e_t);
		@(posedge clk);
		#1 chk(sreq, 1'b0);
	endtask
	task t_regs;
		for (int i = 0; i < 10; i++) rdc(8'h48 + 8'(4 * i), rv[i]);
		for (int i = 0; i < 10; i++) begin
			wrr(8'h48 + 8'(4 * i), 32'hFFFFFFFF);
			rdc(8'h48 + 8'(4 * i), mv[i]);
		end
		wrr(8'h7C, 32'hFFFFFFFF);
		rdc(8'h7C, 32'h0);
		chk(fto, 9'h1FE);
	endtask
	task t_lanes_port;
		det <= 16'h0F0F;
		wrr(8'h4C, 32'h800000A5);
		chk(den, 16'h00A5);
		chk(inc, 16'h0005);
		wrr(8'h4C, 32'h000000A5);
		chk(inc, 16'h0F0F);
		wrr(8'h48, 32'h15);
		chk(lnum, 5'h00);
		chk(dmp, 1'b1);
		wrr(8'h40, 32'h1);
		chk(lnum, 5'h15);
		chk(dmp, 1'b0);
		wrr(8'h50, 32'h0310);
		chk(nfts, 8'h10);
		chk(fto, 9'h013);
	endtask
	task t_speed;
		prate <= 2'h1;
		wrr(8'h54, 32'h80000002);
		attempt(1'b1, 1'b1, 2'h1);
		attempt(1'b0, 1'b0, 2'h0);
		prate <= 2'h3;
		attempt(1'b1, 1'b1, 2'h2);
		wrr(8'h54, 32'h00000003);
		attempt(1'b1, 1'b0, 2'h0);
	endtask
	task t_misc;
		wak <= 1'b1;
		wrr(8'h5C, 32'h0);
		chk({bcn, wpin}, 2'b01);
		wrr(8'h5C, 32'h1);
		chk({bcn, wpin}, 2'b10);
		wrr(8'h60, 32'h1);
		chk({eie, mex}, 5'h11);
		wrr(8'h60, 32'h2);
		chk({eie, mex}, 5'h02);
		ecp <= 1'b1;
		wrr(8'h60, 32'h1);
		chk(mex, 1'b0);
		wrr(8'h6C, 32'hA);
		chk(tsa, 4'h5);
		wrr(8'h64, 32'h80000002);
		ist <= 4'h2;
		#2 chk(icen, 1'b1);
		ist <= 4'h1;
		#2 chk(icen, 1'b1);
		wrr(8'h64, 32'h40000002);
		ist <= 4'h2;
		#2 chk(icen, 1'b0);
		ist <= 4'h4;
		#2 chk(icen, 1'b1);
		@(posedge clk);
		ient <= 1'b1;
		@(posedge clk);
		ient <= 1'b0;
		repeat (14) begin
			@(posedge clk);
			#1 chk(iq, 1'b0);
		end
		@(posedge clk);
		#1 chk(iq, 1'b1);
		rdc(8'h70, 32'hD);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			end_of_test;
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk({pmax, pmin}, 4'hC);
		t_regs;
		t_lanes_port;
		t_speed;
		t_misc;
		end_of_test;
	end
endmodule // testbench
`default_nettype wire
